// >>> debug_link_slave_regs.svh
// constants for the debug link reply encoder
// assumes inclusion by bare name from the package and the design files
`ifndef DEBUG_LINK_SLAVE_REGS_SVH
`define DEBUG_LINK_SLAVE_REGS_SVH
`define SYNC_BYTE        8'h55
`define CMD_SET_GUARD    8'h84
`define CMD_HALT         8'h82
`define RSP_ACK          8'h40
`define RSP_NACK         8'h41
`define RSP_IDCODE       8'hc0
`define RSP_READ_DATA    8'hc1
`define RSP_MEM_STATUS   8'hc2
`define RSP_BAUD         8'hc3
`define RSP_STATUS_WORD  8'hc4
`define RSP_BUS_SPEED    8'hc5
`define ST_OK            8'h00
`define ST_BUSY          8'h01
`define ST_BUS_ERR       8'h02
`define GUARD_RST        2'h0
`define GUARD_BITS_0     8'h80
`define GUARD_BITS_1     8'h10
`define GUARD_BITS_2     8'h04
`define GUARD_BITS_3     8'h01
`define BIT_PROTECTED    8
`define BIT_BUS_BUSY     7
`define BIT_ERASE        6
`define BIT_HALTED       5
`define BIT_RESET_BY_DBG 0
`define IDCODE_DEFAULT   32'h0000_0001
`define BUF_DEPTH_LOG2   8
`endif

// >>> debug_link_slave_pkg.sv
// types shared by the reply encoder and its test bench
// assumes the constants header sits in the same folder
`include "debug_link_slave_regs.svh"
package debug_link_slave_pkg;
    typedef enum logic [2:0] {
        rsp_ack, rsp_nack, rsp_idcode, rsp_read_data,
        rsp_mem_status, rsp_baud, rsp_status_word, rsp_bus_speed
    } rsp_kind_t;

    typedef enum {
        st_idle, st_guard, st_sync, st_code, st_len_hi, st_len_lo,
        st_data, st_trail, st_crc_hi, st_crc_lo
    } tx_state_t;

    // one reply request from the command side
    typedef struct packed {
        rsp_kind_t   kind;
        logic [7:0]  status;
        logic [15:0] count;
        logic [15:0] data_len;
        logic [31:0] word;
    } rsp_req_t;

    // crc value handed in for the packet being sent
    typedef struct packed {
        logic [15:0] crc;
    } crc_t;
endpackage : debug_link_slave_pkg

// >>> read_data_buf.sv
// small memory that holds read data bytes for a read_data_reply
// assumes one writer and one reader on the same clock
`timescale 1ns/10ps
`include "debug_link_slave_regs.svh"
module read_data_buf (
    input  wire logic                         i_clk,
    input  wire logic                         i_we,
    input  wire logic [`BUF_DEPTH_LOG2-1:0]   i_waddr,
    input  wire logic [7:0]                   i_wdata,
    input  wire logic [`BUF_DEPTH_LOG2-1:0]   i_raddr,
    output logic      [7:0]                   o_rdata
);
    logic [7:0] mem [0:(1<<`BUF_DEPTH_LOG2)-1];

    // registered read, write port
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule : read_data_buf

// >>> debug_link_slave.sv
// reply encoder of the single-pin debug link slave
// Summary of operation
// - wait guard time before replying
// - guard code selects 128/16/4/1 bits
// - guard command 0x84 answered ack/nack
// - ack 0x40 after good command
// - nack 0x41 on crc/unknown command
// - id reply 0xc0 carries id word
// - read reply 0xc1 data plus trailer
// - failed read still sends full length
// - sync, code, length, data, crc order
// - status 0 ok, 1 busy, 2 error
// - status reply after write, bad read
// - status reply 0xc2 three bytes
// - baud reply 0xc3 reports rate
// - status word 0xc4, reserved bits zero
// - bit 8 protected, one in reset
// - bit 7 internal bus busy
// - bit 6 until chip erase done
// - bit 5 halted, zero in reset
// - bit 0 debug-issued cpu reset
// - speed reply 0xc5 oscillator cycle count
// - protection restricts memory read/write
// - halt 0x82: 1 halts, 0 resets
// assumes the command side decodes packets and supplies the crc and bit period
// assumes the read buffer is filled before the data phase begins
// assumes device state inputs come from logic on this clock
// assumes the master takes bytes through the valid/ready pair
`timescale 1ns/10ps
`include "debug_link_slave_regs.svh"
module debug_link_slave
    import debug_link_slave_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // command side
    input  wire logic        i_guard_wr,
    input  wire logic [7:0]  i_guard_code,
    input  wire logic        i_halt_wr,
    input  wire logic [7:0]  i_halt_arg,
    input  wire logic        i_mem_cmd,
    input  wire logic        i_mem_cmd_ok,
    input  wire logic        i_rd_we,
    input  wire logic [7:0]  i_rd_wdata,
    input  wire logic        i_req_valid,
    output logic             o_req_ready,
    input  rsp_req_t         i_req,
    input  crc_t             i_crc,
    input  wire logic [15:0] i_bit_period,
    input  wire logic [15:0] i_baud,
    input  wire logic [15:0] i_speed_count,
    // device state
    input  wire logic        i_dev_in_reset,
    input  wire logic        i_fuse_set,
    input  wire logic        i_bus_busy,
    input  wire logic        i_erase_busy,
    input  wire logic        i_cpu_halted,
    input  wire logic        i_dbg_reset,
    // outputs, and the byte ready input
    output logic             o_mem_allowed,
    output logic             o_halt_req,
    output logic             o_dev_reset_pulse,
    output logic [1:0]       o_guard_code,
    output logic [15:0]      o_status_word,
    output logic             o_byte_valid,
    output logic [7:0]       o_byte,
    input  wire logic        i_byte_ready,
    output logic             o_busy
);
    // whole module state, registered in one place
    typedef struct packed {
        tx_state_t                  state;
        logic [1:0]                 guard;
        logic [23:0]                gcnt;
        rsp_req_t                   req;
        logic [15:0]                crc;
        logic [15:0]                len;
        logic [15:0]                idx;
        logic [`BUF_DEPTH_LOG2-1:0] waddr;
        logic                       halt;
        logic                       rst_pulse;
        logic [7:0]                 byte_out;
        logic                       valid;
    } st_t;

    // registered state and its next value
    st_t s_r;
    st_t s_nxt;
    // combinational helpers
    logic [7:0]  buf_rdata;
    logic [15:0] status_word;
    logic [7:0]  guard_bits;
    logic [15:0] data_len;

    // read address comes from the next state, so the registered
    // read data line up with the byte loaded one cycle later
    read_data_buf u_buf (
        .i_clk   (i_clk),
        .i_we    (i_rd_we),
        .i_waddr (s_r.waddr),
        .i_wdata (i_rd_wdata),
        .i_raddr (s_nxt.idx[`BUF_DEPTH_LOG2-1:0]),
        .o_rdata (buf_rdata)
    );

    // status word assembly, reserved bits stay zero
    always_comb begin
        status_word = 16'h0000;
        // reserved bits zero
        // reset forces protection on and halted off
        // protected, forced in reset
        status_word[`BIT_PROTECTED] = i_fuse_set | i_dev_in_reset;
        status_word[`BIT_BUS_BUSY] = i_bus_busy;
        status_word[`BIT_ERASE] = i_erase_busy;
        status_word[`BIT_HALTED] = i_cpu_halted & ~i_dev_in_reset;
        status_word[`BIT_RESET_BY_DBG] = i_dbg_reset;
    end

    // guard length in bit periods
    always_comb begin
        case (s_r.guard)
            2'h0:    guard_bits = `GUARD_BITS_0;
            2'h1:    guard_bits = `GUARD_BITS_1;
            2'h2:    guard_bits = `GUARD_BITS_2;
            default: guard_bits = `GUARD_BITS_3;
        endcase
    end

    // data field length per reply kind
    always_comb begin
        case (i_req.kind)
            // id word is four bytes
            rsp_idcode:      data_len = 16'h0004;
            rsp_read_data:   data_len = i_req.data_len + 16'h0003;
            rsp_mem_status:  data_len = 16'h0003;
            // two-byte fields
            rsp_baud:        data_len = 16'h0002;
            rsp_status_word: data_len = 16'h0002;
            rsp_bus_speed:   data_len = 16'h0002;
            default:         data_len = 16'h0000;
        endcase
    end

    // next-state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.rst_pulse = 1'b0;
        // guard register, used from next reply
        if (i_guard_wr) begin
            s_nxt.guard = i_guard_code[1:0];
        end
        // other halt arguments leave the halt level alone
        // halt argument 1 halts, 0 releases and resets
        if (i_halt_wr) begin
            if (i_halt_arg == 8'h01) begin
                s_nxt.halt = 1'b1;
            end else if (i_halt_arg == 8'h00) begin
                s_nxt.halt = 1'b0;
                s_nxt.rst_pulse = 1'b1;
            end
        end
        // read buffer write pointer
        if (i_rd_we) begin
            s_nxt.waddr = s_r.waddr + 1'b1;
        end
        // a byte stays until the master takes it,
        // so a stall never drops or repeats one
        if (s_r.valid && i_byte_ready) begin
            s_nxt.valid = 1'b0;
        end
        case (s_r.state)
            // take a request, latch its fields and load the guard
            // count; a guard write now only affects the next reply
            st_idle: begin
                if (i_req_valid) begin
                    s_nxt.req = i_req;
                    s_nxt.crc = i_crc.crc;
                    s_nxt.len = data_len;
                    s_nxt.idx = 16'h0000;
                    s_nxt.waddr = '0;
                    s_nxt.gcnt = 24'(guard_bits) * 24'(i_bit_period);
                    s_nxt.state = st_guard;
                end
            end
            // count down the product of guard bits and bit period
            // hold off for guard time
            st_guard: begin
                if (s_r.gcnt <= 24'h000001) begin
                    s_nxt.state = st_sync;
                end else begin
                    s_nxt.gcnt = s_r.gcnt - 24'h000001;
                end
            end
            default: begin
                if (!s_r.valid || i_byte_ready) begin
                    s_nxt.valid = 1'b1;
                    case (s_r.state)
                        // sync byte opens every reply
                        st_sync: begin
                            s_nxt.byte_out = `SYNC_BYTE;
                            s_nxt.state = st_code;
                        end
                        // reply code from the request kind
                        st_code: begin
                            case (s_r.req.kind)
                                rsp_ack:         s_nxt.byte_out = `RSP_ACK;
                                rsp_nack:        s_nxt.byte_out = `RSP_NACK;
                                rsp_idcode:      s_nxt.byte_out = `RSP_IDCODE;
                                rsp_read_data:   s_nxt.byte_out = `RSP_READ_DATA;
                                rsp_mem_status:  s_nxt.byte_out = `RSP_MEM_STATUS;
                                rsp_baud:        s_nxt.byte_out = `RSP_BAUD;
                                rsp_status_word: s_nxt.byte_out = `RSP_STATUS_WORD;
                                default:         s_nxt.byte_out = `RSP_BUS_SPEED;
                            endcase
                            s_nxt.state = st_len_hi;
                        end
                        // length field, msb first
                        st_len_hi: begin
                            s_nxt.byte_out = s_r.len[15:8];
                            s_nxt.state = st_len_lo;
                        end
                        // then data, trailer or crc
                        st_len_lo: begin
                            s_nxt.byte_out = s_r.len[7:0];
                            if (s_r.len == 16'h0000) begin
                                s_nxt.state = st_crc_hi;
                            end else if (s_r.req.kind == rsp_read_data
                                         && s_r.req.data_len != 16'h0000) begin
                                s_nxt.state = st_data;
                            end else begin
                                s_nxt.state = st_trail;
                            end
                        end
                        // bytes after a bus error go out as buffered
                        // full length sent even after error
                        st_data: begin
                            s_nxt.byte_out = buf_rdata;
                            s_nxt.idx = s_r.idx + 16'h0001;
                            if (s_r.idx + 16'h0001 == s_r.req.data_len) begin
                                s_nxt.idx = 16'h0000;
                                s_nxt.state = st_trail;
                            end
                        end
                        // trailer or fixed-size data field
                        st_trail: begin
                            s_nxt.idx = s_r.idx + 16'h0001;
                            s_nxt.byte_out = 8'h00;
                            case (s_r.req.kind)
                                // id word, msb first
                                rsp_idcode: begin
                                    case (s_r.idx[1:0])
                                        2'h0:    s_nxt.byte_out = s_r.req.word[31:24];
                                        2'h1:    s_nxt.byte_out = s_r.req.word[23:16];
                                        2'h2:    s_nxt.byte_out = s_r.req.word[15:8];
                                        default: s_nxt.byte_out = s_r.req.word[7:0];
                                    endcase
                                end
                                // live 16-bit fields, msb first
                                rsp_baud: begin
                                    s_nxt.byte_out = s_r.idx[0] ? i_baud[7:0]
                                                                : i_baud[15:8];
                                end
                                rsp_status_word: begin
                                    s_nxt.byte_out = s_r.idx[0] ? status_word[7:0]
                                                                : status_word[15:8];
                                end
                                rsp_bus_speed: begin
                                    s_nxt.byte_out = s_r.idx[0] ? i_speed_count[7:0]
                                                                : i_speed_count[15:8];
                                end
                                default: begin
                                    // status byte then count msb first
                                    case (s_r.idx[1:0])
                                        2'h0:    s_nxt.byte_out = s_r.req.status;
                                        2'h1:    s_nxt.byte_out = s_r.req.count[15:8];
                                        default: s_nxt.byte_out = s_r.req.count[7:0];
                                    endcase
                                end
                            endcase
                            if (s_r.idx + 16'h0001 == (s_r.req.kind == rsp_read_data
                                    ? 16'h0003 : s_r.len)) begin
                                s_nxt.state = st_crc_hi;
                            end
                        end
                        // crc msb then lsb, back to idle
                        st_crc_hi: begin
                            s_nxt.byte_out = s_r.crc[15:8];
                            s_nxt.state = st_crc_lo;
                        end
                        st_crc_lo: begin
                            s_nxt.byte_out = s_r.crc[7:0];
                            s_nxt.state = st_idle;
                        end
                        // unused state codes fall back to idle
                        default: begin
                            s_nxt.state = st_idle;
                        end
                    endcase
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_r       <= '0;
            s_r.state <= st_idle;
            s_r.guard <= `GUARD_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // handshake and memory gate outputs
    assign o_req_ready       = (s_r.state == st_idle);
    assign o_mem_allowed     = ~(i_fuse_set | i_dev_in_reset);
    // registered control and data outputs, status word combinational
    assign o_halt_req        = s_r.halt;
    assign o_dev_reset_pulse = s_r.rst_pulse;
    assign o_guard_code      = s_r.guard;
    assign o_status_word     = status_word;
    assign o_byte_valid      = s_r.valid;
    assign o_byte            = s_r.byte_out;
    // busy until the last byte has been taken
    assign o_busy            = (s_r.state != st_idle) | s_r.valid;
endmodule : debug_link_slave

// >>> debug_link_slave_checker.sv
// concurrent checks on the reply encoder ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module debug_link_slave_checker (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_guard_wr,
    input wire logic [7:0]  i_guard_code,
    input wire logic        i_halt_wr,
    input wire logic [7:0]  i_halt_arg,
    input wire logic        i_req_valid,
    input wire logic        o_req_ready,
    input wire logic [15:0] i_bit_period,
    input wire logic        i_dev_in_reset,
    input wire logic        i_fuse_set,
    input wire logic        i_bus_busy,
    input wire logic        i_erase_busy,
    input wire logic        i_cpu_halted,
    input wire logic        i_dbg_reset,
    input wire logic        o_mem_allowed,
    input wire logic        o_halt_req,
    input wire logic        o_dev_reset_pulse,
    input wire logic [1:0]  o_guard_code,
    input wire logic [15:0] o_status_word,
    input wire logic        o_byte_valid,
    input wire logic [7:0]  o_byte,
    input wire logic        i_byte_ready
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic        wait_r;
    logic [15:0] gcnt_r;
    logic [15:0] gexp_r;
    // link bits of wait per guard code
    function automatic logic [15:0] gbits(input logic [1:0] c);
        return (c == 2'h0) ? 16'h0080 : (c == 2'h1) ? 16'h0010 : (c == 2'h2) ? 16'h0004 : 16'h0001;
    endfunction : gbits
    // counts cycles from request take to the first reply byte
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wait_r <= 1'b0;
            gcnt_r <= 16'h0000;
            gexp_r <= 16'h0000;
        end else if (i_req_valid && o_req_ready) begin
            wait_r <= 1'b1;
            gcnt_r <= 16'h0000;
            gexp_r <= 16'(gbits(o_guard_code) * i_bit_period);
        end else begin
            wait_r <= wait_r && !o_byte_valid;
            gcnt_r <= gcnt_r + 16'h0001;
        end
    end
    sequence s_first;
        wait_r && o_byte_valid;
    endsequence
    sequence s_release;
        i_halt_wr && i_halt_arg == 8'h00;
    endsequence
    sequence s_pulse;
        o_dev_reset_pulse && !o_halt_req ##1 !o_dev_reset_pulse;
    endsequence
    AST_GUARD_WAIT: assert property (
        s_first |-> gcnt_r >= gexp_r && gcnt_r <= gexp_r + 16'h0002)
        else $error("first reply byte outside guard window");
    AST_SYNC_FIRST: assert property (
        s_first |-> o_byte == 8'h55) else $error("reply does not open with sync");
    AST_BYTE_HOLD: assert property (
        o_byte_valid && !i_byte_ready |=> o_byte_valid && $stable(o_byte))
        else $error("reply byte dropped before accept");
    AST_GUARD_REG: assert property (
        i_guard_wr |=> o_guard_code == $past(i_guard_code[1:0]))
        else $error("guard code not stored");
    AST_HALT_SET: assert property (
        i_halt_wr && i_halt_arg == 8'h01 |=> o_halt_req) else $error("halt not raised");
    AST_HALT_REL: assert property (
        s_release |=> s_pulse) else $error("halt release without reset pulse");
    AST_RSV_ZERO: assert property (
        o_status_word[15:9] == 7'h00 && o_status_word[4:1] == 4'h0)
        else $error("reserved status bits set");
    AST_PROT_BIT: assert property (
        o_status_word[8] == (i_fuse_set || i_dev_in_reset)) else $error("protect bit wrong");
    AST_HALT_BIT: assert property (
        o_status_word[5] == (i_cpu_halted && !i_dev_in_reset)) else $error("halted bit wrong");
    AST_STATE_BITS: assert property (
        o_status_word[7] == i_bus_busy && o_status_word[6] == i_erase_busy
        && o_status_word[0] == i_dbg_reset) else $error("busy, erase or reset bit wrong");
    AST_MEM_GATE: assert property (
        o_mem_allowed == !o_status_word[8]) else $error("memory access gate wrong");
endmodule : debug_link_slave_checker
bind debug_link_slave debug_link_slave_checker debug_link_slave_checker_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_guard_wr(i_guard_wr), .i_guard_code(i_guard_code),
    .i_halt_wr(i_halt_wr), .i_halt_arg(i_halt_arg), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_bit_period(i_bit_period), .i_dev_in_reset(i_dev_in_reset),
    .i_fuse_set(i_fuse_set), .i_bus_busy(i_bus_busy), .i_erase_busy(i_erase_busy),
    .i_cpu_halted(i_cpu_halted), .i_dbg_reset(i_dbg_reset), .o_mem_allowed(o_mem_allowed),
    .o_halt_req(o_halt_req), .o_dev_reset_pulse(o_dev_reset_pulse),
    .o_guard_code(o_guard_code), .o_status_word(o_status_word), .o_byte_valid(o_byte_valid),
    .o_byte(o_byte), .i_byte_ready(i_byte_ready));

// >>> link_master_model.sv
// receiving side of the external link master, stalls at random
// assumes the bench drives i_stall and empties rx_q per reply
`timescale 1ns/10ps
module link_master_model (
    input  wire logic       i_clk,
    input  wire logic       i_stall,
    input  wire logic       i_byte_valid,
    input  wire logic [7:0] i_byte,
    output logic            o_byte_ready
);
    logic [7:0] rx_q[$];
    always @(posedge i_clk) begin
        if (i_byte_valid && o_byte_ready)
            rx_q.push_back(i_byte);
        o_byte_ready <= !i_stall;
    end
    function automatic int bus_clk(input int f_link, input int cv);
        return (3 * f_link) / (cv - 3);
    endfunction : bus_clk
endmodule : link_master_model

// >>> single_pin_debug_responses_tb_top.sv
// self-checking bench for the reply encoder
// assumes the model and checker files are compiled before it
`timescale 1ns/10ps
module single_pin_debug_responses_tb_top;
    import debug_link_slave_pkg::*;
    logic        clk, rst, guard_wr, halt_wr, rd_we, req_valid, req_ready, stall;
    logic        in_rst, fuse, bbusy, erase, halted, dbg_rst, mem_ok, halt_req, rst_pulse;
    logic        bvalid, bready, busy;
    logic [7:0]  guard_code, halt_arg, rd_wdata, bdata;
    logic [1:0]  gcode;
    logic [15:0] baud, speed, sw, sw_o, bitp;
    logic [15:0] lf = 16'h003f;
    rsp_req_t    req;
    crc_t        crc;
    int          n_fail = 0;
    int          cmp_count = 0;
    logic [7:0]  exp_q[$];
    logic [7:0]  rd_q[$];
    logic [7:0]  codes[8] = '{8'h40, 8'h41, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5};
    debug_link_slave debug_link_slave_i (
        .i_clk(clk), .i_rst(rst), .i_guard_wr(guard_wr), .i_guard_code(guard_code),
        .i_halt_wr(halt_wr), .i_halt_arg(halt_arg), .i_mem_cmd(1'b0), .i_mem_cmd_ok(1'b0),
        .i_rd_we(rd_we), .i_rd_wdata(rd_wdata), .i_req_valid(req_valid),
        .o_req_ready(req_ready), .i_req(req), .i_crc(crc), .i_bit_period(bitp),
        .i_baud(baud), .i_speed_count(speed), .i_dev_in_reset(in_rst), .i_fuse_set(fuse),
        .i_bus_busy(bbusy), .i_erase_busy(erase), .i_cpu_halted(halted),
        .i_dbg_reset(dbg_rst), .o_mem_allowed(mem_ok), .o_halt_req(halt_req),
        .o_dev_reset_pulse(rst_pulse), .o_guard_code(gcode), .o_status_word(sw_o),
        .o_byte_valid(bvalid), .o_byte(bdata), .i_byte_ready(bready), .o_busy(busy));
    link_master_model link_master_model_i (
        .i_clk(clk), .i_stall(stall), .i_byte_valid(bvalid), .i_byte(bdata),
        .o_byte_ready(bready));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction : rnd
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // whole packet: sync, code, length, data field, crc
    function automatic void exp_pkt(input rsp_req_t r);
        logic [7:0]  d[$];
        logic [15:0] l;
        case (r.kind)
            rsp_idcode:      d = {r.word[31:24], r.word[23:16], r.word[15:8], r.word[7:0]};
            rsp_read_data:   d = {rd_q, r.status, r.count[15:8], r.count[7:0]};
            rsp_mem_status:  d = {r.status, r.count[15:8], r.count[7:0]};
            rsp_baud:        d = {baud[15:8], baud[7:0]};
            rsp_status_word: d = {sw[15:8], sw[7:0]};
            rsp_bus_speed:   d = {speed[15:8], speed[7:0]};
            default:         d = {};
        endcase
        l = 16'(d.size());
        exp_q = {8'h55, codes[r.kind], l[15:8], l[7:0], d, crc.crc[15:8], crc.crc[7:0]};
    endfunction : exp_pkt
    task automatic set_guard(input logic [1:0] g);
        guard_wr <= 1'b1;
        guard_code <= {6'(rnd()), g};
        @(posedge clk);
        guard_wr <= 1'b0;
        @(posedge clk);
        chk(gcode, g);
    endtask : set_guard
    task automatic halt(input logic [7:0] a);
        halt_wr <= 1'b1;
        halt_arg <= a;
        @(posedge clk);
        halt_wr <= 1'b0;
        @(posedge clk);
        chk(halt_req, a[0]);
        chk(rst_pulse, !a[0]);
    endtask : halt
    // one reply of kind k after setting guard code g
    task automatic reply(input rsp_kind_t k, input logic [1:0] g);
        rsp_req_t r;
        int       n;
        set_guard(g);
        n = 1 + int'(rnd() % 4);
        r.kind = k;
        r.status = 8'(rnd() % 3);
        r.count = rnd();
        r.data_len = 16'(n);
        r.word = {rnd(), rnd()};
        rd_q = {};
        repeat (n) rd_q.push_back(8'(rnd()));
        link_master_model_i.rx_q = {};
        {in_rst, fuse, bbusy, erase, halted, dbg_rst} <= 6'(rnd());
        {baud, speed, crc} <= {rnd(), rnd(), rnd()};
        bitp <= 16'(1 + rnd() % 8);
        req <= r;
        req_valid <= 1'b1;
        @(posedge clk);
        for (int t = 0; t < 20 && !req_ready; t++)
            @(posedge clk);
        req_valid <= 1'b0;
        foreach (rd_q[i]) begin
            rd_we <= 1'b1;
            rd_wdata <= rd_q[i];
            @(posedge clk);
        end
        rd_we <= 1'b0;
        sw = {7'h00, fuse | in_rst, bbusy, erase, halted & ~in_rst, 4'h0, dbg_rst};
        chk(mem_ok, !(fuse | in_rst));
        chk(sw_o, sw);
        chk(busy, 1'b1);
        exp_pkt(r);
        for (int t = 0; t < 4000 && link_master_model_i.rx_q.size() < exp_q.size(); t++)
            @(posedge clk);
        repeat (4) @(posedge clk);
        chk(busy, 1'b0);
        chk(32'(link_master_model_i.rx_q.size()), 32'(exp_q.size()));
        foreach (exp_q[i]) chk(link_master_model_i.rx_q[i], exp_q[i]);
    endtask : reply
    always @(posedge clk) stall <= (rnd() < 16'h5000);
    initial begin
        {guard_wr, halt_wr, rd_we, req_valid, in_rst, fuse, bbusy, erase, halted} = '0;
        {dbg_rst, guard_code, halt_arg, rd_wdata, baud, speed, bitp} = '0;
        req = '0;
        crc = '0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        halt(8'h01);
        halt(8'h00);
        for (int k = 0; k < 8; k++)
            reply(rsp_kind_t'(k), 2'(k));
        repeat (12) reply(rsp_kind_t'(rnd() % 8), 2'(rnd()));
        // shortest guard while the read buffer fills
        reply(rsp_read_data, 2'h3);
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
endmodule : single_pin_debug_responses_tb_top
